// file: design/cca_pkg.sv
// Constants and types of the counter array with six capture/compare modules.
// Assumes APB word addressing: byte address is four times a register index.
package cca_pkg;

  localparam int CCA_NUM_MODULES = 6;
  localparam int CCA_ADDR_W = 10;
  localparam int CCA_DATA_W = 32;

  // Register indices; byte address = index * 4
  localparam logic [7:0] CCA_STATUS_IDX = 8'hd8;
  localparam logic [7:0] CCA_MASK_IDX = 8'hd9;
  localparam logic [7:0] CCA_CNT_LO_IDX = 8'hf9;
  localparam logic [7:0] CCA_CNT_HI_IDX = 8'hfa;
  localparam logic [7:0] CCA_MODE_IDX [CCA_NUM_MODULES] = '{
    8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf};
  localparam logic [7:0] CCA_VAL_LO_IDX [CCA_NUM_MODULES] = '{
    8'hfb, 8'hfd, 8'he9, 8'heb, 8'hed, 8'he1};
  localparam logic [7:0] CCA_VAL_HI_IDX [CCA_NUM_MODULES] = '{
    8'hfc, 8'hfe, 8'hea, 8'hec, 8'hee, 8'he2};

  // Status and mask layout
  localparam int CCA_RUN_BIT = 6;
  localparam int CCA_OVF_BIT = 7;
  localparam logic [7:0] CCA_STATUS_RESET = 8'h00;
  localparam logic [7:0] CCA_MASK_RESET = 8'hbf;
  localparam logic [7:0] CCA_MASK_USED = 8'hbf;
  localparam logic [7:0] CCA_BYTE_ZERO = 8'h00;
  localparam logic [7:0] CCA_BYTE_MAX = 8'hff;
  localparam logic [15:0] CCA_COUNT_MAX = 16'hffff;
  localparam logic [15:0] CCA_COUNT_RESET = 16'h0000;
  localparam logic [15:0] CCA_VALUE_RESET = 16'h0000;

  // Mode byte, most significant field first
  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_mod_enable;
    logic module_irq_enable;
  } cca_mode_type;

  localparam cca_mode_type CCA_MODE_RESET = cca_mode_type'(8'h00);

  typedef enum logic [2:0] {
    CCA_SEL_NONE = 3'b000,
    CCA_SEL_CNT_LO = 3'b001,
    CCA_SEL_CNT_HI = 3'b010,
    CCA_SEL_VAL_LO = 3'b011,
    CCA_SEL_VAL_HI = 3'b100,
    CCA_SEL_MODE = 3'b101,
    CCA_SEL_STATUS = 3'b110,
    CCA_SEL_MASK = 3'b111
  } cca_sel_type;

  typedef struct packed {
    cca_sel_type sel;
    logic [2:0] module_idx;
  } cca_decode_type;

endpackage

// file: design/cca_counter_array.sv
// Counter array: 16-bit counter shared by six capture/compare modules, APB slave.
// Assumes capture pins are asynchronous to pclk; outputs feed pins directly.
//
// Behaviour
// (R1) PWM is 16-bit when wide_pwm_select is one, else 8-bit.
// (R2) Comparator function acts only while compare_enable is one.
// (R3) Rising input edges capture only while rise_capture_enable is one.
// (R4) Falling input edges capture only while fall_capture_enable is one; both allowed.
// (R5) With match_flag_enable, a counter match sets module_event_flag.
// (R6) With toggle_enable, a counter match inverts module_output_pin.
// (R7) Toggle plus pulse modulation gives frequency output, not PWM.
// (R8) With pulse_mod_enable, module_output_pin carries a PWM waveform.
// (R9) Module interrupt requested when event flag set and module_irq_enable is one; code also needs the module's mask_reg bit set.
// (R10) Counter bits 7..0 readable and writable as counter_low_byte.
// (R11) Counter bits 15..8 readable and writable as counter_high_byte.
// (R12) Module value bits 7..0 readable and writable as compare_low_byte.
// (R13) Module value bits 15..8 readable and writable as compare_high_byte.
// (R14) Event flag set by match or capture, cleared only by software.
// (R15) Writing low byte clears compare_enable; writing high byte sets it.
// (R16) 8-bit PWM: high on low-byte match, low on wrap, reload low from high.
// (R17) 16-bit PWM: high on full match, low on counter overflow.
// (R18) Enabled capture edge copies counter into value and sets event flag.
// (R19) Six identical modules share one counter; mode and data reset to zero.
`timescale 1ns/1ns

module cca_counter_array (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cca_pkg::CCA_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cca_pkg::CCA_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [cca_pkg::CCA_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cca_pkg::CCA_NUM_MODULES-1:0] capture_pin,
  output logic [cca_pkg::CCA_NUM_MODULES-1:0] module_output_pin,
  output logic irq
);

  localparam int NM = cca_pkg::CCA_NUM_MODULES;

  // Address decode, shared by read mux and write strobes
  function automatic cca_pkg::cca_decode_type cca_decode(
    input logic [cca_pkg::CCA_ADDR_W-1:0] addr
  );
    cca_pkg::cca_decode_type d;
    logic [7:0] idx;
    d.sel = cca_pkg::CCA_SEL_NONE;
    d.module_idx = 3'h0;
    idx = addr[cca_pkg::CCA_ADDR_W-1:2];
    if (addr[1:0] == 2'h0) begin
      if (idx == cca_pkg::CCA_STATUS_IDX) begin
        d.sel = cca_pkg::CCA_SEL_STATUS;
      end
      if (idx == cca_pkg::CCA_MASK_IDX) begin
        d.sel = cca_pkg::CCA_SEL_MASK;
      end
      if (idx == cca_pkg::CCA_CNT_LO_IDX) begin
        d.sel = cca_pkg::CCA_SEL_CNT_LO;
      end
      if (idx == cca_pkg::CCA_CNT_HI_IDX) begin
        d.sel = cca_pkg::CCA_SEL_CNT_HI;
      end
      for (int m = 0; m < NM; m++) begin
        if (idx == cca_pkg::CCA_MODE_IDX[m]) begin
          d.sel = cca_pkg::CCA_SEL_MODE;
          d.module_idx = 3'(m);
        end
        if (idx == cca_pkg::CCA_VAL_LO_IDX[m]) begin
          d.sel = cca_pkg::CCA_SEL_VAL_LO;
          d.module_idx = 3'(m);
        end
        if (idx == cca_pkg::CCA_VAL_HI_IDX[m]) begin
          d.sel = cca_pkg::CCA_SEL_VAL_HI;
          d.module_idx = 3'(m);
        end
      end
    end
    return d;
  endfunction

  cca_pkg::cca_decode_type dec;
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rd_value;

  logic [15:0] count_reg;
  logic [NM-1:0] flag_reg;
  logic run_reg;
  logic ovf_reg;
  logic [7:0] status_value;
  logic [7:0] mask_reg;
  cca_pkg::cca_mode_type mode_reg [NM];
  logic [15:0] value_reg [NM];

  logic [NM-1:0] sync1_reg;
  logic [NM-1:0] sync2_reg;
  logic [NM-1:0] sync3_reg;
  logic [NM-1:0] stable_reg;

  logic run;
  logic ovf_event;
  logic low_wrap;
  logic [NM-1:0] rise_ev;
  logic [NM-1:0] fall_ev;
  logic [NM-1:0] capture_hit;
  logic [NM-1:0] full_match;
  logic [NM-1:0] low_match;
  logic [NM-1:0] freq_mode;
  logic [NM-1:0] pwm8_mode;
  logic [NM-1:0] pwm16_mode;
  logic [NM-1:0] toggle_only;
  logic [NM-1:0] event_set;
  logic [NM-1:0] irq_enable_vec;
  logic irq_next;

  assign dec = cca_decode(paddr);
  assign access = psel & penable & pready;
  assign wr = access & pwrite & pstrb[0] & (dec.sel != cca_pkg::CCA_SEL_NONE);
  assign wbyte = pwdata[7:0];
  assign run = run_reg;

  // APB answer: one wait state, so pready and prdata come from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & penable & !pready) begin
      pready <= 1'b1;
      pslverr <= (dec.sel == cca_pkg::CCA_SEL_NONE);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read data holds until the next answer, so a late sample still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & penable & !pready) begin
      prdata <= {24'h000000, rd_value};
    end
  end

  // Read mux
  always_comb begin
    case (dec.sel)
      cca_pkg::CCA_SEL_CNT_LO: rd_value = count_reg[7:0]; // R10
      cca_pkg::CCA_SEL_CNT_HI: rd_value = count_reg[15:8]; // R11
      cca_pkg::CCA_SEL_VAL_LO: rd_value = value_reg[dec.module_idx][7:0]; // R12
      cca_pkg::CCA_SEL_VAL_HI: rd_value = value_reg[dec.module_idx][15:8]; // R13
      cca_pkg::CCA_SEL_MODE: rd_value = mode_reg[dec.module_idx];
      cca_pkg::CCA_SEL_STATUS: rd_value = status_value;
      cca_pkg::CCA_SEL_MASK: rd_value = mask_reg;
      default: rd_value = cca_pkg::CCA_BYTE_ZERO;
    endcase
  end

  // Counter events; matches only while counting so a stopped counter
  // cannot toggle an output on every clock
  assign ovf_event = run & (count_reg == cca_pkg::CCA_COUNT_MAX);
  assign low_wrap = run & (count_reg[7:0] == cca_pkg::CCA_BYTE_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= cca_pkg::CCA_COUNT_RESET;
    end else if (wr & (dec.sel == cca_pkg::CCA_SEL_CNT_LO)) begin
      count_reg <= {count_reg[15:8], wbyte}; // R10
    end else if (wr & (dec.sel == cca_pkg::CCA_SEL_CNT_HI)) begin
      count_reg <= {wbyte, count_reg[7:0]}; // R11
    end else if (run) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Capture pin synchronisers, three stages; an edge counts once
  // stages two and three agree on a new level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= capture_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Held level of each input; idles low like the pins, so no false edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_reg <= '0;
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (sync2_reg[m] == sync3_reg[m]) begin
          stable_reg[m] <= sync3_reg[m];
        end
      end
    end
  end

  // Per-module decode of modes and events
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      rise_ev[m] = (sync2_reg[m] == sync3_reg[m]) & sync3_reg[m] & !stable_reg[m];
      fall_ev[m] = (sync2_reg[m] == sync3_reg[m]) & !sync3_reg[m] & stable_reg[m];
      capture_hit[m] = (rise_ev[m] & mode_reg[m].rise_capture_enable) // R3
        | (fall_ev[m] & mode_reg[m].fall_capture_enable); // R4
      full_match[m] = run & mode_reg[m].compare_enable // R2
        & (count_reg == value_reg[m]);
      low_match[m] = run & mode_reg[m].compare_enable // R2
        & (count_reg[7:0] == value_reg[m][7:0]);
      freq_mode[m] = mode_reg[m].toggle_enable & mode_reg[m].pulse_mod_enable; // R7
      pwm8_mode[m] = mode_reg[m].pulse_mod_enable & !mode_reg[m].toggle_enable
        & !mode_reg[m].wide_pwm_select; // R1 R8
      pwm16_mode[m] = mode_reg[m].pulse_mod_enable & !mode_reg[m].toggle_enable
        & mode_reg[m].wide_pwm_select; // R1 R8
      toggle_only[m] = mode_reg[m].toggle_enable & !mode_reg[m].pulse_mod_enable;
      event_set[m] = capture_hit[m] // R18
        | (mode_reg[m].match_flag_enable
           & ((freq_mode[m] | pwm8_mode[m]) ? low_match[m] : full_match[m])); // R5
      irq_enable_vec[m] = mode_reg[m].module_irq_enable;
    end
  end

  // Mode registers; compare_enable follows value byte writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < NM; m++) begin
        mode_reg[m] <= cca_pkg::CCA_MODE_RESET; // R19
      end
    end else if (wr) begin
      for (int m = 0; m < NM; m++) begin
        if (dec.module_idx == 3'(m)) begin
          if (dec.sel == cca_pkg::CCA_SEL_MODE) begin
            mode_reg[m] <= cca_pkg::cca_mode_type'(wbyte);
          end
          if (dec.sel == cca_pkg::CCA_SEL_VAL_LO) begin
            mode_reg[m].compare_enable <= 1'b0; // R15
          end
          if (dec.sel == cca_pkg::CCA_SEL_VAL_HI) begin
            mode_reg[m].compare_enable <= 1'b1; // R15
          end
        end
      end
    end
  end

  // Value registers; a software write beats a same-cycle capture or reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < NM; m++) begin
        value_reg[m] <= cca_pkg::CCA_VALUE_RESET; // R19
      end
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (wr & (dec.module_idx == 3'(m)) & (dec.sel == cca_pkg::CCA_SEL_VAL_LO)) begin
          value_reg[m][7:0] <= wbyte; // R12
        end else if (wr & (dec.module_idx == 3'(m)) & (dec.sel == cca_pkg::CCA_SEL_VAL_HI)) begin
          value_reg[m][15:8] <= wbyte; // R13
        end else if (capture_hit[m]) begin
          value_reg[m] <= count_reg; // R18
        end else if (freq_mode[m] & low_match[m]) begin
          value_reg[m][7:0] <= value_reg[m][7:0] + value_reg[m][15:8]; // R7
        end else if (pwm8_mode[m] & low_wrap) begin
          value_reg[m][7:0] <= value_reg[m][15:8]; // R16
        end
      end
    end
  end

  // Output pins; in 8-bit PWM a match on the wrap count wins over the wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_output_pin <= '0;
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (freq_mode[m]) begin
          if (low_match[m]) begin
            module_output_pin[m] <= !module_output_pin[m]; // R7
          end
        end else if (pwm8_mode[m]) begin
          if (low_match[m]) begin
            module_output_pin[m] <= 1'b1; // R16
          end else if (low_wrap) begin
            module_output_pin[m] <= 1'b0; // R16
          end
        end else if (pwm16_mode[m]) begin
          if (full_match[m]) begin
            module_output_pin[m] <= 1'b1; // R17
          end else if (ovf_event) begin
            module_output_pin[m] <= 1'b0; // R17
          end
        end else if (toggle_only[m] & full_match[m]) begin
          module_output_pin[m] <= !module_output_pin[m]; // R6
        end
      end
    end
  end
  // R8: pwm8_mode and pwm16_mode together cover every pulse_mod_enable case without toggle_enable

  // Write strobe of one register kind, shared by the status processes
  function automatic logic wr_sel(input cca_pkg::cca_sel_type sel);
    return wr & (dec.sel == sel);
  endfunction

  // Event flags: write-one-to-clear, and a same-cycle set wins so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= cca_pkg::CCA_STATUS_RESET[NM-1:0];
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (event_set[m]) begin
          flag_reg[m] <= 1'b1; // R14
        end else if (wr_sel(cca_pkg::CCA_SEL_STATUS) & wbyte[m]) begin
          flag_reg[m] <= 1'b0; // R14
        end
      end
    end
  end

  // Run control, plain read and write; counter stopped after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= cca_pkg::CCA_STATUS_RESET[cca_pkg::CCA_RUN_BIT];
    end else if (wr_sel(cca_pkg::CCA_SEL_STATUS)) begin
      run_reg <= wbyte[cca_pkg::CCA_RUN_BIT];
    end
  end

  // Overflow flag, write-one-to-clear; set wins as for the event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= cca_pkg::CCA_STATUS_RESET[cca_pkg::CCA_OVF_BIT];
    end else if (ovf_event) begin
      ovf_reg <= 1'b1;
    end else if (wr_sel(cca_pkg::CCA_SEL_STATUS) & wbyte[cca_pkg::CCA_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  // Status byte as software reads it
  always_comb begin
    status_value = cca_pkg::CCA_STATUS_RESET;
    status_value[NM-1:0] = flag_reg;
    status_value[cca_pkg::CCA_RUN_BIT] = run_reg;
    status_value[cca_pkg::CCA_OVF_BIT] = ovf_reg;
  end

  // Mask register, bit 6 unused and reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= cca_pkg::CCA_MASK_RESET;
    end else if (wr & (dec.sel == cca_pkg::CCA_SEL_MASK)) begin
      mask_reg <= wbyte & cca_pkg::CCA_MASK_USED;
    end
  end

  // Interrupt: level, one cycle behind the flags it reflects
  assign irq_next = (|(flag_reg & mask_reg[NM-1:0] & irq_enable_vec)) // R9
    | (ovf_reg & mask_reg[cca_pkg::CCA_OVF_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

endmodule

// file: verif/cca_pin_model.sv
// Far-side model of the capture pins of the counter array.
// Assumes the caller stands just after a pclk edge; levels hold between calls.
`timescale 1ns/1ns
module cca_pin_model (
  input wire logic pclk,
  output logic [5:0] capture_pin
);
  initial capture_pin = 6'h00;
  // Edge lands after a clock edge, never on the falling one
  task automatic set_pin(input int i, input logic lvl);
    @(posedge pclk);
    capture_pin[i] <= lvl;
  endtask
endmodule

// file: verif/cca_monitor.sv
// Checker of APB timing and of pin and interrupt causes of the counter array.
// Sees only the top ports; mode and mask writes are shadowed from the bus.
`timescale 1ns/1ns
module cca_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cca_pkg::CCA_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cca_pkg::CCA_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [cca_pkg::CCA_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [cca_pkg::CCA_NUM_MODULES-1:0] capture_pin,
  input wire logic [cca_pkg::CCA_NUM_MODULES-1:0] module_output_pin,
  input wire logic irq
);
  logic [7:0] mode_sh [6];
  logic mask7_sh, wr_cyc, en_irq;
  logic [5:0] en_pin;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr_cyc = psel && pwrite;
  // Over-approximate enables: mask bits of modules are not shadowed
  always_comb begin
    en_irq = mask7_sh;
    for (int i = 0; i < 6; i++) begin
      en_irq = en_irq || mode_sh[i][0];
      en_pin[i] = mode_sh[i][6] && (mode_sh[i][2] || mode_sh[i][1]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        mode_sh[i] <= 8'h00;
      end
      mask7_sh <= 1'b1;
    end else if (wr_cyc && penable && pready && pstrb[0] && !pslverr) begin
      for (int i = 0; i < 6; i++) begin
        if (paddr[9:2] == cca_pkg::CCA_MODE_IDX[i]) begin
          mode_sh[i] <= pwdata[7:0];
        end
        if (paddr[9:2] == cca_pkg::CCA_VAL_LO_IDX[i]) begin
          mode_sh[i][6] <= 1'b0;
        end
        if (paddr[9:2] == cca_pkg::CCA_VAL_HI_IDX[i]) begin
          mode_sh[i][6] <= 1'b1;
        end
      end
      if (paddr[9:2] == cca_pkg::CCA_MASK_IDX) begin
        mask7_sh <= pwdata[7];
      end
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; !pready ##1 pready; endsequence
  property p_rdy_wait; s_setup |=> s_wait; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not in second access cycle");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  property p_rd_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data above byte not zero");
  property p_err_map; pready && paddr[9:2] == 8'h00 |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_rst; $rose(presetn) |-> !pready && !irq && module_output_pin == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_pin_cause; ((module_output_pin ^ $past(module_output_pin)) & ~$past(en_pin)) == 6'h00; endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved without compare mode");
  property p_irq_cause; $rose(irq) |-> en_irq || $past(en_irq); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enable");
  property p_irq_hold; irq && !wr_cyc && !$past(wr_cyc) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without write");
endmodule
bind cca_counter_array cca_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .capture_pin(capture_pin), .module_output_pin(module_output_pin), .irq(irq));

// file: verif/cca_counter_array_tb.sv
// Self-checking bench of the counter array: APB master, capture pins, pin timing.
// Assumes one wait state per APB access and a 20 MHz pclk.
`timescale 1ns/1ns
module cca_counter_array_tb;
  localparam logic [7:0] ST = cca_pkg::CCA_STATUS_IDX;
  localparam logic [7:0] MK = cca_pkg::CCA_MASK_IDX;
  localparam logic [7:0] CL = cca_pkg::CCA_CNT_LO_IDX;
  localparam logic [7:0] CH = cca_pkg::CCA_CNT_HI_IDX;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [5:0] capture_pin, module_output_pin;
  logic [15:0] v, cap;
  int n_fail, checks, m, c;
  cca_counter_array u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .module_output_pin(module_output_pin), .irq(irq));
  cca_pin_model u_pins (.pclk(pclk), .capture_pin(capture_pin));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until ready is sampled; one idle cycle keeps drivers race-free
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, {24'h0, exp});
  endtask
  task automatic wr16(input logic [7:0] li, input logic [7:0] hi, input logic [15:0] d);
    apb(1'b1, li, d[7:0]);
    apb(1'b1, hi, d[15:8]);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    n_fail = 0;
    checks = 0;
    void'($urandom(32'h72d11173));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rdc("mode_rst", cca_pkg::CCA_MODE_IDX[i], 8'h00);
      rdc("vlo_rst", cca_pkg::CCA_VAL_LO_IDX[i], 8'h00);
      rdc("vhi_rst", cca_pkg::CCA_VAL_HI_IDX[i], 8'h00);
      for (int j = 0; j < 2; j++) begin
        v = 16'($urandom());
        apb(1'b1, cca_pkg::CCA_VAL_LO_IDX[i], v[7:0]);
        rdc("ecom_clr", cca_pkg::CCA_MODE_IDX[i], 8'h00);
        apb(1'b1, cca_pkg::CCA_VAL_HI_IDX[i], v[15:8]);
        rdc("ecom_set", cca_pkg::CCA_MODE_IDX[i], 8'h40);
      end
      rdc("val_lo", cca_pkg::CCA_VAL_LO_IDX[i], v[7:0]);
      rdc("val_hi", cca_pkg::CCA_VAL_HI_IDX[i], v[15:8]);
    end
    rdc("mask_rst", MK, cca_pkg::CCA_MASK_RESET);
    rdc("cnt_rst", CH, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    v = 16'($urandom());
    wr16(CL, CH, v);
    rdc("cnt_lo", CL, v[7:0]);
    rdc("cnt_hi", CH, v[15:8]);
    m = $urandom_range(5);
    v = 16'($urandom_range(16'he000, 16'h1000));
    wr16(cca_pkg::CCA_VAL_LO_IDX[m], cca_pkg::CCA_VAL_HI_IDX[m], v);
    apb(1'b1, cca_pkg::CCA_MODE_IDX[m], 8'h4d);
    wr16(CL, CH, v - 16'd20);
    apb(1'b1, ST, 8'h40);
    repeat (40) @(posedge pclk);
    chk("toggle", {26'h0, module_output_pin}, 32'h1 << m);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rdc("match", ST, 8'h40 | 8'(1 << m));
    apb(1'b1, ST, 8'(1 << m));
    apb(1'b1, cca_pkg::CCA_MODE_IDX[m], 8'h00);
    rdc("flag_clr", ST, 8'h00);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    c = (m + 1) % 6;
    apb(1'b1, cca_pkg::CCA_MODE_IDX[c], 8'h21);
    apb(1'b1, MK, 8'hbf ^ 8'(1 << c));
    v = 16'($urandom_range(16'hc000));
    wr16(CL, CH, v);
    apb(1'b1, ST, 8'h40);
    u_pins.set_pin(c, 1'b1);
    repeat (10) @(posedge pclk);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rdc("rise_cap", ST, 8'h40 | 8'(1 << c));
    apb(1'b0, cca_pkg::CCA_VAL_LO_IDX[c], 8'h00);
    cap[7:0] = rd[7:0];
    apb(1'b0, cca_pkg::CCA_VAL_HI_IDX[c], 8'h00);
    cap[15:8] = rd[7:0];
    chk("cap_val", {31'h0, (cap - v) inside {[16'd1:16'd24]}}, 32'h1);
    apb(1'b1, MK, 8'hbf);
    @(posedge pclk);
    chk("irq_unmask", {31'h0, irq}, 32'h1);
    apb(1'b1, cca_pkg::CCA_MODE_IDX[c], 8'h11);
    apb(1'b1, ST, 8'h40 | 8'(1 << c));
    u_pins.set_pin(c, 1'b0);
    repeat (10) @(posedge pclk);
    rdc("fall_cap", ST, 8'h40 | 8'(1 << c));
    apb(1'b1, ST, 8'h40 | 8'(1 << c));
    u_pins.set_pin(c, 1'b1);
    repeat (10) @(posedge pclk);
    rdc("no_rise", ST, 8'h40);
    c = (m + 2) % 6;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ST, 8'hbf);
      wr16(cca_pkg::CCA_VAL_LO_IDX[c], cca_pkg::CCA_VAL_HI_IDX[c], 16'hfff8);
      apb(1'b1, cca_pkg::CCA_MODE_IDX[c], k == 2 ? 8'h46 : (k == 1 ? 8'h42 : 8'hc2));
      wr16(CL, CH, 16'hfff0);
      apb(1'b1, ST, 8'h40);
      repeat (4) @(posedge pclk);
      chk("pwm_low", {31'h0, module_output_pin[c]}, 32'h0);
      repeat (8) @(posedge pclk);
      chk("pwm_high", {31'h0, module_output_pin[c]}, 32'h1);
      repeat (12) @(posedge pclk);
      chk("pwm_wrap", {31'h0, module_output_pin[c]}, 32'(k == 2));
      rdc("pwm_reload", cca_pkg::CCA_VAL_LO_IDX[c], k == 2 ? 8'hf7 : (k == 1 ? 8'hff : 8'hf8));
    end
    end_sim();
  end
endmodule
